/* File: verilog/reu_core.sv */
// Functional notes
// RULE1 - full receive queue write: drop byte, abort, enter overrun state, raise 0x06.
// RULE2 - host should flush the receive queue after overrun, then restart reception.
// RULE3 - raise 0x07 when receive enable becomes all zeros.
// RULE4 - raise 0x08 when the full frame length has been received.
// RULE5 - with filtering on, raise 0x09 on acceptance decision only.
// RULE6 - with matching on, raise 0x0A when matching completes, any result.
// RULE7 - on a match, raise 0x0B immediately before 0x0A.
// RULE8 - 0x0C active at threshold or stored frame, held during overrun.
// RULE9 - raise 0x0D on delimiter received in receive or sent in transmit.
// RULE10 - raise 0x0E/0x0F on low/high operation success, never on fail or abort.
// RULE11 - abort instruction, raise 0x10 on bad address, 0x11 on bad context.
// RULE12 - select released on byte boundary with operands missing: abort, raise 0x12.
// RULE13 - select released mid byte: serial transfer aborted, raise 0x13.
// RULE14 - raise 0x14 on no lock within 256 us, or lock loss in receive.
// RULE15 - raise 0x15 on reception abort, unless caused by overrun.
// RULE16 - raise 0x16 on buffer move wait expiry; 0x17 never raised.
// RULE17 - any single flag can be routed to a pin by its code.
// RULE18 - two masked OR channels, each routable to a pin.
// RULE19 - complementary channel outputs; channel two codes 0x22 and 0x24.
// RULE20 - pin outputs follow stored flags; flags clear only by written zero.
// RULE21 - two fixed error channels on pins, no status bit, no complement.
// RULE22 - two binding slots fire a chosen strobe when bound exception occurs.
// RULE23 - a clear in the same cycle as the event leaves the flag set.
// RULE24 - status bits 5 and 4 show masked flags of channel one and two.
// RULE25 - flags set on detection, regardless of masks and bindings.
`timescale 1ns/1ps
module reu_core (
    input  wire logic                                          clk,
    input  wire logic                                          rst,
    input  wire logic [reu_pkg::NUM_EXTERNAL-1:0]              other_events,
    input  wire logic                                          rx_mode,
    input  wire logic                                          tx_mode,
    input  wire logic                                          rxq_write,
    input  wire logic                                          rxq_full,
    input  wire logic                                          flush_receive_strobe,
    input  wire logic [reu_pkg::RXEN_W-1:0]                    rx_enable,
    input  wire logic                                          length_reached,
    input  wire logic                                          filter_enable,
    input  wire logic                                          filter_decided,
    input  wire logic                                          filter_accept,
    input  wire logic                                          match_enable,
    input  wire logic                                          match_finished,
    input  wire logic                                          match_hit,
    input  wire logic [reu_pkg::LEVEL_W-1:0]                   rxq_filtered_level,
    input  wire logic [reu_pkg::LEVEL_W-1:0]                   rx_threshold,
    input  wire logic                                          frame_stored,
    input  wire logic                                          delimiter_rx,
    input  wire logic                                          delimiter_tx,
    input  wire logic                                          low_op_end,
    input  wire logic                                          high_op_end,
    input  wire logic                                          op_failed,
    input  wire logic                                          illegal_address_seen,
    input  wire logic                                          context_violation,
    input  wire logic                                          serial_select_bar,
    input  wire logic [reu_pkg::BITCNT_W-1:0]                  serial_bit_count,
    input  wire logic                                          operands_pending,
    input  wire logic                                          synth_lock,
    input  wire logic                                          reception_abort_req,
    input  wire logic                                          move_wait_expired,
    input  wire logic                                          flag_write,
    input  wire logic [reu_pkg::NUM_EXC-1:0]                   flag_write_data,
    input  wire logic [reu_pkg::NUM_EXC-1:0]                   channel_one_mask,
    input  wire logic [reu_pkg::NUM_EXC-1:0]                   channel_two_mask,
    input  wire logic [reu_pkg::NUM_PINS*reu_pkg::CODE_W-1:0]  pin_control,
    input  wire logic [reu_pkg::CODE_W-1:0]                    bind_x_cmd,
    input  wire logic [reu_pkg::CODE_W-1:0]                    bind_x_cfg,
    input  wire logic [reu_pkg::CODE_W-1:0]                    bind_y_cmd,
    input  wire logic [reu_pkg::CODE_W-1:0]                    bind_y_cfg,
    output logic                                               rxq_discard,
    output logic                                               rx_abort,
    output logic                                               instr_abort,
    output logic                                               overrun_state,
    output logic [reu_pkg::NUM_EXC-1:0]                        exception_flags,
    output logic                                               status_chan_one,
    output logic                                               status_chan_two,
    output logic [reu_pkg::NUM_PINS-1:0]                       pin_out,
    output logic                                               bind_x_fire,
    output logic [reu_pkg::CODE_W-1:0]                         bind_x_code,
    output logic                                               bind_y_fire,
    output logic [reu_pkg::CODE_W-1:0]                         bind_y_code
);
    import reu_pkg::*;

    logic [NUM_EXC-1:0]    exc_events;
    logic [NUM_EXC-1:0]    flags_nxt;
    logic [NUM_EXC-1:0]    clear_bits;
    logic                  overrun_hit;
    logic [RXEN_W-1:0]     rx_enable_r;
    logic                  match_pending_r;
    logic                  sel_meta_r;
    logic                  sel_sync_r;
    logic                  sel_prev_r;
    logic                  sel_release;
    logic                  lock_meta_r;
    logic                  lock_sync_r;
    logic                  lock_prev_r;
    logic                  rx_mode_prev_r;
    logic [LOCK_CNT_W-1:0] lock_cnt_r;
    logic                  lock_wait_r;
    logic                  lock_timeout;
    logic                  chan_one_nxt;
    logic                  chan_two_nxt;

    assign overrun_hit = rxq_write && rxq_full;
    assign rxq_discard = overrun_hit; // [RULE1]
    assign sel_release = sel_sync_r && !sel_prev_r;
    assign lock_timeout = lock_wait_r && (32'(lock_cnt_r) == LOCK_WAIT_CYC - 1) && !lock_sync_r;

    // overrun state lasts until the host flushes the queue
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_state <= 1'b0;
        end else if (overrun_hit) begin
            overrun_state <= 1'b1; // [RULE1]
        end else if (flush_receive_strobe) begin
            overrun_state <= 1'b0; // [RULE2]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_abort    <= 1'b0;
            instr_abort <= 1'b0;
        end else begin
            rx_abort    <= overrun_hit || reception_abort_req; // [RULE1]
            instr_abort <= illegal_address_seen || context_violation
                           || (sel_release && (serial_bit_count != 3'h0 || operands_pending)); // [RULE11] [RULE12]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_enable_r     <= 8'h00;
            match_pending_r <= 1'b0;
        end else begin
            rx_enable_r     <= rx_enable;
            match_pending_r <= match_enable && match_finished;
        end
    end

    // serial select is a pin: two flops before any decision
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_meta_r  <= 1'b1;
            sel_sync_r  <= 1'b1;
            sel_prev_r  <= 1'b1;
            lock_meta_r <= 1'b0;
            lock_sync_r <= 1'b0;
            lock_prev_r <= 1'b0;
        end else begin
            sel_meta_r  <= serial_select_bar;
            sel_sync_r  <= sel_meta_r;
            sel_prev_r  <= sel_sync_r;
            lock_meta_r <= synth_lock;
            lock_sync_r <= lock_meta_r;
            lock_prev_r <= lock_sync_r;
        end
    end

    // lock wait timer started on entry to receive mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_mode_prev_r <= 1'b0;
            lock_cnt_r     <= 12'h000;
            lock_wait_r    <= 1'b0;
        end else begin
            rx_mode_prev_r <= rx_mode;
            if (!rx_mode || lock_sync_r || lock_timeout) begin
                lock_wait_r <= 1'b0;
                lock_cnt_r  <= 12'h000;
            end else if (!rx_mode_prev_r) begin
                lock_wait_r <= 1'b1;
                lock_cnt_r  <= 12'h000;
            end else if (lock_wait_r) begin
                lock_cnt_r  <= lock_cnt_r + 12'h001; // [RULE14]
            end
        end
    end

    always_comb begin
        exc_events                     = '0;
        exc_events[NUM_EXTERNAL-1:0]   = other_events;
        exc_events[EXC_RX_OVERRUN]     = overrun_hit; // [RULE1]
        exc_events[EXC_RXEN_CLEARED]   = (rx_enable_r != 8'h00) && (rx_enable == 8'h00); // [RULE3]
        exc_events[EXC_FRAME_RECEIVED] = length_reached; // [RULE4]
        exc_events[EXC_FRAME_ACCEPTED] = filter_enable && filter_decided && filter_accept; // [RULE5]
        exc_events[EXC_MATCH_FOUND]    = match_enable && match_finished && match_hit; // [RULE7]
        exc_events[EXC_MATCH_COMPLETE] = match_pending_r; // [RULE6] [RULE7]
        exc_events[EXC_RX_THRESHOLD]   = (rxq_filtered_level >= rx_threshold) || frame_stored
                                         || overrun_state; // [RULE8]
        exc_events[EXC_DELIMITER]      = (delimiter_rx && rx_mode) || (delimiter_tx && tx_mode); // [RULE9]
        exc_events[EXC_LOW_OP_DONE]    = low_op_end && !op_failed; // [RULE10]
        exc_events[EXC_HIGH_OP_DONE]   = high_op_end && !op_failed; // [RULE10]
        exc_events[EXC_ADDR_FAULT]     = illegal_address_seen; // [RULE11]
        exc_events[EXC_CONTEXT_FAULT]  = context_violation; // [RULE11]
        exc_events[EXC_OPERAND_FAULT]  = sel_release && serial_bit_count == 3'h0 && operands_pending; // [RULE12]
        exc_events[EXC_SERIAL_FAULT]   = sel_release && serial_bit_count != 3'h0; // [RULE13]
        exc_events[EXC_LOCK_MISSING]   = lock_timeout || (rx_mode && lock_prev_r && !lock_sync_r); // [RULE14]
        exc_events[EXC_RX_ABANDONED]   = reception_abort_req && !overrun_hit; // [RULE15]
        exc_events[EXC_MOVE_TIMEOUT]   = move_wait_expired; // [RULE16]
        exc_events[EXC_RESERVED]       = 1'b0; // [RULE16]
    end

    // set beats clear so an event in the clearing cycle is kept
    assign clear_bits = flag_write ? ~flag_write_data : '0; // [RULE20]
    assign flags_nxt  = (exception_flags & ~clear_bits) | exc_events; // [RULE23] [RULE25]
    assign chan_one_nxt = |(flags_nxt & channel_one_mask);
    assign chan_two_nxt = |(flags_nxt & channel_two_mask);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exception_flags <= FLAGS_RESET;
        end else begin
            exception_flags <= flags_nxt; // [RULE20] [RULE25]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_chan_one <= 1'b0;
            status_chan_two <= 1'b0;
        end else begin
            status_chan_one <= chan_one_nxt; // [RULE24]
            status_chan_two <= chan_two_nxt; // [RULE24]
        end
    end

    // pins decode from next flags so each pin matches the stored flag
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
            logic [CODE_W-1:0] code;
            logic [CODE_W-1:0] idx;
            assign code = pin_control[gp*CODE_W +: CODE_W];
            assign idx  = code - PIN_SINGLE_FIRST;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pin_out[gp] <= 1'b0;
                end else begin
                    if (code >= PIN_SINGLE_FIRST && code <= PIN_SINGLE_LAST) begin
                        pin_out[gp] <= flags_nxt[idx[EXC_W-1:0]]; // [RULE17] [RULE20]
                    end else begin
                        case (code)
                            PIN_CHAN_A:      pin_out[gp] <= chan_one_nxt; // [RULE18]
                            PIN_CHAN_B:      pin_out[gp] <= chan_two_nxt; // [RULE18] [RULE19]
                            PIN_CHAN_A_COMP: pin_out[gp] <= |(flags_nxt & ~channel_one_mask); // [RULE19]
                            PIN_CHAN_B_COMP: pin_out[gp] <= |(flags_nxt & ~channel_two_mask); // [RULE19]
                            PIN_RX_ERRORS:   pin_out[gp] <= flags_nxt[EXC_RX_UNDERFLOW] | flags_nxt[EXC_RX_OVERRUN]
                                                 | flags_nxt[EXC_RX_ABANDONED] | flags_nxt[EXC_MOVE_TIMEOUT]; // [RULE21]
                            PIN_GEN_ERRORS:  pin_out[gp] <= flags_nxt[EXC_ADDR_FAULT] | flags_nxt[EXC_CONTEXT_FAULT]
                                                 | flags_nxt[EXC_OPERAND_FAULT] | flags_nxt[EXC_SERIAL_FAULT]; // [RULE21]
                            default:         pin_out[gp] <= 1'b0;
                        endcase
                    end
                end
            end
        end
    endgenerate

    reu_bind_slot u_bind_x (
        .clk        (clk),
        .rst        (rst),
        .cmd_sel    (bind_x_cmd),
        .bind_cfg   (bind_x_cfg),
        .exc_events (exc_events),
        .fire       (bind_x_fire),
        .fire_code  (bind_x_code)
    );

    reu_bind_slot u_bind_y (
        .clk        (clk),
        .rst        (rst),
        .cmd_sel    (bind_y_cmd),
        .bind_cfg   (bind_y_cfg),
        .exc_events (exc_events),
        .fire       (bind_y_fire),
        .fire_code  (bind_y_code)
    );

    sequence s_overrun_write;
        rxq_write && rxq_full;
    endsequence

    sequence s_match_hit;
        match_enable && match_finished && match_hit;
    endsequence

    chk_overrun_flag: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        s_overrun_write |=> exception_flags[EXC_RX_OVERRUN] && overrun_state && rx_abort)
        else $error("overrun not flagged");
    chk_rxen_zero: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        ($past(rx_enable) != 8'h00 && rx_enable == 8'h00) |=> exception_flags[EXC_RXEN_CLEARED])
        else $error("enable clear missed");
    // match complete comes one cycle after match found
    chk_match_order: assert property (@(posedge clk) disable iff (rst) // [RULE6] [RULE7]
        s_match_hit |=> exception_flags[EXC_MATCH_FOUND] ##1 exception_flags[EXC_MATCH_COMPLETE])
        else $error("match order wrong");
    chk_threshold_held: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        overrun_state |=> exception_flags[EXC_RX_THRESHOLD]) else $error("threshold not held in overrun");
    chk_op_fail: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        (low_op_end && op_failed && !$past(exception_flags[EXC_LOW_OP_DONE]) && !flag_write)
        |=> exception_flags[EXC_LOW_OP_DONE] == $past(exception_flags[EXC_LOW_OP_DONE]))
        else $error("failed op flagged");
    chk_serial_abort: assert property (@(posedge clk) disable iff (rst) // [RULE13]
        (sel_release && serial_bit_count != 3'h0) |=> exception_flags[EXC_SERIAL_FAULT] && instr_abort)
        else $error("serial abort missed");
    chk_reserved_clear: assert property (@(posedge clk) disable iff (rst) // [RULE16]
        !exception_flags[EXC_RESERVED]) else $error("reserved flag set");
    chk_set_wins: assert property (@(posedge clk) disable iff (rst) // [RULE23]
        (flag_write && exc_events[EXC_FRAME_RECEIVED]) |=> exception_flags[EXC_FRAME_RECEIVED])
        else $error("clear beat event");
    chk_flag_sticky: assert property (@(posedge clk) disable iff (rst) // [RULE20]
        (exception_flags[EXC_FRAME_ACCEPTED] && !(flag_write && !flag_write_data[EXC_FRAME_ACCEPTED]))
        |=> exception_flags[EXC_FRAME_ACCEPTED]) else $error("flag dropped");
    chk_status_one: assert property (@(posedge clk) disable iff (rst) // [RULE24]
        status_chan_one == |(exception_flags & $past(channel_one_mask))) else $error("status bit 5 wrong");
    chk_status_two: assert property (@(posedge clk) disable iff (rst) // [RULE24]
        status_chan_two == |(exception_flags & $past(channel_two_mask))) else $error("status bit 4 wrong");
endmodule : reu_core

/* File: verilog/reu_pkg.sv */
package reu_pkg;
    localparam int unsigned NUM_EXC      = 24;
    localparam int unsigned EXC_W        = 5;
    localparam int unsigned NUM_PINS     = 6;
    localparam int unsigned CODE_W       = 8;
    localparam int unsigned LEVEL_W      = 8;
    localparam int unsigned RXEN_W       = 8;
    localparam int unsigned BITCNT_W     = 3;

    // exception numbers
    localparam logic [EXC_W-1:0] EXC_RX_UNDERFLOW   = 5'h05;
    localparam logic [EXC_W-1:0] EXC_RX_OVERRUN     = 5'h06;
    localparam logic [EXC_W-1:0] EXC_RXEN_CLEARED   = 5'h07;
    localparam logic [EXC_W-1:0] EXC_FRAME_RECEIVED = 5'h08;
    localparam logic [EXC_W-1:0] EXC_FRAME_ACCEPTED = 5'h09;
    localparam logic [EXC_W-1:0] EXC_MATCH_COMPLETE = 5'h0a;
    localparam logic [EXC_W-1:0] EXC_MATCH_FOUND    = 5'h0b;
    localparam logic [EXC_W-1:0] EXC_RX_THRESHOLD   = 5'h0c;
    localparam logic [EXC_W-1:0] EXC_DELIMITER      = 5'h0d;
    localparam logic [EXC_W-1:0] EXC_LOW_OP_DONE    = 5'h0e;
    localparam logic [EXC_W-1:0] EXC_HIGH_OP_DONE   = 5'h0f;
    localparam logic [EXC_W-1:0] EXC_ADDR_FAULT     = 5'h10;
    localparam logic [EXC_W-1:0] EXC_CONTEXT_FAULT  = 5'h11;
    localparam logic [EXC_W-1:0] EXC_OPERAND_FAULT  = 5'h12;
    localparam logic [EXC_W-1:0] EXC_SERIAL_FAULT   = 5'h13;
    localparam logic [EXC_W-1:0] EXC_LOCK_MISSING   = 5'h14;
    localparam logic [EXC_W-1:0] EXC_RX_ABANDONED   = 5'h15;
    localparam logic [EXC_W-1:0] EXC_MOVE_TIMEOUT   = 5'h16;
    localparam logic [EXC_W-1:0] EXC_RESERVED       = 5'h17;
    localparam int unsigned      NUM_EXTERNAL       = 6;

    // pin output codes: single flags sit at exception number plus one
    localparam logic [CODE_W-1:0] PIN_SINGLE_FIRST  = 8'h01;
    localparam logic [CODE_W-1:0] PIN_SINGLE_LAST   = 8'h18;
    localparam logic [CODE_W-1:0] PIN_CHAN_A        = 8'h21;
    localparam logic [CODE_W-1:0] PIN_CHAN_B        = 8'h22;
    localparam logic [CODE_W-1:0] PIN_CHAN_A_COMP   = 8'h23;
    localparam logic [CODE_W-1:0] PIN_CHAN_B_COMP   = 8'h24;
    localparam logic [CODE_W-1:0] PIN_RX_ERRORS     = 8'h25;
    localparam logic [CODE_W-1:0] PIN_GEN_ERRORS    = 8'h26;

    // binding slot second register layout
    localparam int unsigned BIND_EN_BIT = 7;
    localparam int unsigned BIND_NUM_HI = 4;

    // synthesizer lock wait
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned LOCK_WAIT_NS   = 256_000;
    localparam int unsigned LOCK_WAIT_CYC  = LOCK_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned LOCK_CNT_W     = 12;

    localparam logic [NUM_EXC-1:0] FLAGS_RESET = 24'h00_0000;
endpackage : reu_pkg

/* File: verilog/reu_bind_slot.sv */
`timescale 1ns/1ps
module reu_bind_slot (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [reu_pkg::CODE_W-1:0]  cmd_sel,
    input  wire logic [reu_pkg::CODE_W-1:0]  bind_cfg,
    input  wire logic [reu_pkg::NUM_EXC-1:0] exc_events,
    output logic                             fire,
    output logic [reu_pkg::CODE_W-1:0]       fire_code
);
    import reu_pkg::*;

    logic [EXC_W-1:0] sel_num;
    logic             hit;

    assign sel_num = bind_cfg[BIND_NUM_HI:0];
    // numbers past the table never fire rather than alias a real flag
    assign hit = bind_cfg[BIND_EN_BIT] && (32'(sel_num) < NUM_EXC) && exc_events[sel_num];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fire      <= 1'b0;
            fire_code <= 8'h00;
        end else begin
            fire      <= hit; // [RULE22]
            fire_code <= cmd_sel;
        end
    end

    chk_bind_fire: assert property (@(posedge clk) disable iff (rst)
        hit |=> fire && fire_code == $past(cmd_sel)) else $error("bound strobe not fired"); // [RULE22]
endmodule : reu_bind_slot

/* File: test/reu_host.sv */
`timescale 1ns/1ps
module reu_host (
    input  wire logic                   clk,
    input  wire logic                   overrun_state,
    output logic                        flag_write = 1'b0,
    output logic [reu_pkg::NUM_EXC-1:0] flag_write_data = '1,
    output logic                        flush_receive_strobe = 1'b0
);
    import reu_pkg::*;
    // one pulse per overrun, a held strobe would flush later frames too
    always @(posedge clk) flush_receive_strobe <= #10 overrun_state && !flush_receive_strobe;
    task automatic clear(input logic [NUM_EXC-1:0] d);
        @(posedge clk) #10 {flag_write, flag_write_data} = {1'b1, d};
        @(posedge clk) #10 {flag_write, flag_write_data} = {1'b0, {NUM_EXC{1'b1}}};
    endtask : clear
endmodule : reu_host

/* File: test/tb_radio_exception_unit.sv */
`timescale 1ns/1ps
module tb_radio_exception_unit;
    import reu_pkg::*;
    localparam time D = 10ns;
    logic               clk = 1'b0, rst = 1'b1, rxm = 1'b0, opnd = 1'b0;
    logic [2:0]         bcnt = 3'h3;
    logic [NUM_EXC-1:0] ev = '0, ef = '0, m1 = '0, m2 = '0, add;
    logic [5:0][7:0]    pc = 48'h2625_2423_2200;
    logic [7:0]         rxv = 8'h01, bxc = '0, bcy = 8'h0d;
    logic [31:0]        seed = 32'hec02;
    int                 error_cnt = 0, compares = 0;
    int                 ks[24] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 23, 10, 11, 12, 13, 18, 14, 15, 16, 17, 19, 20, 21, 22};
    wire                flag_write, flush_receive_strobe, rxq_discard, overrun_state, bind_x_fire, bind_y_fire;
    wire                status_chan_one, status_chan_two, rx_abort, instr_abort;
    wire [NUM_EXC-1:0]  flag_write_data, exception_flags;
    wire [5:0]          pin_out;
    wire [7:0]          bind_x_code, bind_y_code;
    always #50 clk = ~clk;
    reu_host host_u (.clk, .overrun_state, .flag_write, .flag_write_data, .flush_receive_strobe);
    reu_core dut_u (
        .clk, .rst, .other_events(ev[5:0]), .rx_mode(rxm), .tx_mode(1'b0), .rxq_write(ev[6]), .rxq_full(ev[6]),
        .flush_receive_strobe, .rx_enable(ev[7] ? 8'h00 : rxv), .length_reached(ev[8]), .filter_enable(rxm),
        .filter_decided(ev[9] | ev[23]), .filter_accept(ev[9]), .match_enable(rxm), .match_hit(ev[11]),
        .match_finished(ev[10] | ev[11]), .rxq_filtered_level(8'h00), .rx_threshold(rxv), .frame_stored(ev[20]),
        .delimiter_rx(ev[13]), .delimiter_tx(ev[18]), .low_op_end(ev[14] | ev[12]), .high_op_end(ev[15]),
        .op_failed(ev[12]), .illegal_address_seen(ev[16]), .context_violation(ev[17]), .synth_lock(~ev[20]),
        .serial_select_bar(~ev[19]), .serial_bit_count(bcnt), .operands_pending(opnd), .flag_write,
        .reception_abort_req(ev[21]), .move_wait_expired(ev[22]), .flag_write_data, .channel_one_mask(m1),
        .channel_two_mask(m2), .pin_control(pc), .bind_x_cmd(bxc), .bind_x_cfg(bcy ^ 8'h04), .bind_y_cmd(~bxc),
        .bind_y_cfg(bcy), .rxq_discard, .rx_abort, .instr_abort, .overrun_state, .exception_flags,
        .status_chan_one, .status_chan_two, .pin_out, .bind_x_fire, .bind_x_code, .bind_y_fire, .bind_y_code);
    function automatic logic pin_of(input logic [7:0] c);
        case (c)
            8'h21, 8'h22, 8'h23, 8'h24: return |(ef & ((c[0] ? m1 : m2) ^ {NUM_EXC{c > 8'h22}}));
            8'h25: return ef[5] | ef[6] | ef[21] | ef[22];
            8'h26: return |ef[19:16];
            default: return (c >= 8'h01 && c <= 8'h18) ? ef[c - 8'h01] : 1'b0;
        endcase
    endfunction : pin_of
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        error_cnt += (g !== e);
        if (g !== e) $display("BAD %s expected %h seen %h", n, e, g);
    endtask : cmp
    task automatic look();
        cmp("flags", ef, exception_flags);
        for (int i = 0; i < 6; i++) cmp("pin", pin_of(pc[i]), pin_out[i]);
        cmp("status", {|(ef & m1), |(ef & m2)}, {status_chan_one, status_chan_two});
    endtask : look
    task automatic hit(input int k, input int hold);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        {m1, bxc} = seed;
        {rxv, m2, bcy[7]} = {seed[31:24] | 8'h01, seed[7:0], seed[31:16], seed[3]};
        pc[0] = seed[1] ? 8'(k + 1) : 8'h21;
        // a four cycle select pulse ends on a byte boundary with operands owed
        {bcnt, opnd} = {(hold == 4) ? 3'h0 : 3'h3, k == 19};
        case (k)
            6: add = 24'h00_1040;
            11: add = 24'h00_0c00;
            12, 18, 23: add = '0;
            19: add = (hold == 4) ? 24'h04_0000 : 24'h08_0000;
            20: add = 24'h10_1000;
            default: add = 24'h00_0001 << k;
        endcase
        ev[k] = 1'b1;
        #1 cmp("discard", k == 6, rxq_discard);
        repeat (hold) @(posedge clk);
        #D ev = '0;
        ef |= add;
        if (hold == 1) begin
            cmp("order", ef & 24'hff_ebff, exception_flags & 24'hff_efff);
            cmp("fire", {k == 9 && bcy[7], k == 13 && bcy[7]}, {bind_x_fire, bind_y_fire});
            cmp("code", {bxc, ~bxc}, {bind_x_code, bind_y_code});
            cmp("abort", {k == 6 || k == 21, k == 16 || k == 17}, {rx_abort, instr_abort});
        end
        repeat (5) @(posedge clk);
        #D look();
        $display("test %0d done", k);
    endtask : hit
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // whole run needs well under 400 cycles
    initial begin
        #100us error_cnt++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        #D {rst, rxm} = 2'b01;
        foreach (ks[i]) begin
            hit(ks[i], (ks[i] == 19 || ks[i] == 20) ? 3 : 1);
            host_u.clear(24'h00_0000);
            ef = '0;
            look();
        end
        hit(19, 4);
        hit(14, 1);
        ef = '0;
        // the event lands on the very edge that carries the clear
        fork
            host_u.clear(24'h00_0000);
            @(posedge clk) #D hit(8, 1);
        join
        summarize();
    end
endmodule : tb_radio_exception_unit
